// File: rtl/hplrm_tick_div.sv
`timescale 1ns/1ns
module hplrm_tick_div #(
  parameter int unsigned DIV = 208
) (
  input  wire logic clock_i,
  input  wire logic srst_i,
  output logic      tick_o
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else if (cnt_reg == W'(DIV - 1)) begin
      cnt_reg <= '0;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_o  <= 1'b0;
    end
  end
endmodule

// File: rtl/hplrm_top.sv
`timescale 1ns/1ns
module hplrm_top #(
  parameter int unsigned HOLD_DOWN_CYC = hplrm_pkg::HOLD_DOWN_CYC,
  parameter int unsigned SETTLE_CYC    = hplrm_pkg::SETTLE_CYC,
  parameter int unsigned FS_DIV        = hplrm_pkg::FS_DIV,
  parameter int unsigned PUMP_DIV      = hplrm_pkg::PUMP_DIV,
  parameter int          VOL_W         = 8
) (
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  input  wire logic             hp_insert_i,
  input  wire logic             ret_above_i,
  input  wire logic [5:0]       sig_atten_i,
  output logic                  tone_o,
  output logic      [1:0]       rbank_sel_o,
  output logic                  meas_active_o,
  output logic      [1:0]       rail_level_o,
  output logic                  headphone_power_down_o,
  output logic                  analog_mute_ch_a_o,
  output logic                  analog_mute_ch_b_o,
  output logic                  playback_highpass_enable_o,
  output logic                  supply_latch_select_o,
  output logic      [1:0]       load_compensation_setting_o,
  output logic      [VOL_W-1:0] vol_applied_o,
  output logic                  irq_o
);
  // ==========================================================
  // Types and local signals
  typedef enum logic [2:0] {
    LD_IDLE   = 3'b000,
    LD_RES_HI = 3'b001,
    LD_RES_LO = 3'b010,
    LD_CAP    = 3'b011,
    LD_DONE   = 3'b100
  } hplrm_ld_state_t;

  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam int HW = $clog2(HOLD_DOWN_CYC + 1);
  localparam int TW = $clog2(hplrm_pkg::TONE_HALF_CYC + 1);
  localparam int IRQ_W_L = hplrm_pkg::IRQ_W;

  hplrm_ld_state_t ld_state_reg;
  hplrm_ld_state_t ld_state_next;

  logic [31:0]        ctrl_reg;
  logic [7:0]         ramp_reg;
  logic [VOL_W-1:0]   vol_reg;
  logic [1:0]         res_stat_reg;
  logic               cap_stat_reg;
  logic               done_reg;
  logic [IRQ_W_L-1:0] istat_reg;
  logic [IRQ_W_L-1:0] imask_reg;
  logic [IRQ_W_L-1:0] ev_set;
  logic [1:0]         lcomp_reg;
  logic [SW-1:0]      settle_reg;
  logic [HW-1:0]      hold_reg;
  logic [TW-1:0]      tone_cnt_reg;
  logic               ins_s1_reg;
  logic               ins_s2_reg;
  logic               ins_d_reg;
  logic               ret_s1_reg;
  logic               ret_s2_reg;
  logic               fs_tick;
  logic               pump_tick;
  logic               settled;
  logic               setup_ok;
  logic [2:0]         mode;
  logic [1:0]         need_lvl;
  logic [1:0]         rail_next;
  logic [17:0]        thr;

  assign mode = ctrl_reg[hplrm_pkg::CTL_MODE +: 3];

  // ==========================================================
  // Rate dividers
  hplrm_tick_div #(.DIV(FS_DIV)) u_fs_div (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .tick_o  (fs_tick)
  );

  hplrm_tick_div #(.DIV(PUMP_DIV)) u_pump_div (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .tick_o  (pump_tick)
  );

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ins_s1_reg <= 1'b0;
      ins_s2_reg <= 1'b0;
      ins_d_reg  <= 1'b0;
      ret_s1_reg <= 1'b0;
      ret_s2_reg <= 1'b0;
    end else begin
      ins_s1_reg <= hp_insert_i;
      ins_s2_reg <= ins_s1_reg;
      ins_d_reg  <= ins_s2_reg;
      ret_s1_reg <= ret_above_i;
      ret_s2_reg <= ret_s1_reg;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_reg  <= hplrm_pkg::CTRL_RST;
      ramp_reg  <= '0;
      vol_reg   <= '0;
      imask_reg <= '0;
      lcomp_reg <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == hplrm_pkg::ADDR_CTRL) begin
        ctrl_reg <= reg_wdata_i & 32'h0000_773f;
      end else if (reg_addr_i == hplrm_pkg::ADDR_RAMP) begin
        ramp_reg <= reg_wdata_i[7:0];
      end else if (reg_addr_i == hplrm_pkg::ADDR_VOL) begin
        vol_reg <= reg_wdata_i[VOL_W-1:0];
      end else if (reg_addr_i == hplrm_pkg::ADDR_IMASK) begin
        imask_reg <= reg_wdata_i[IRQ_W_L-1:0];
      end else if (reg_addr_i == hplrm_pkg::ADDR_LCOMP) begin
        // Changing compensation on a live amplifier risks instability
        if (ctrl_reg[hplrm_pkg::CTL_PDN]) begin
          lcomp_reg <= reg_wdata_i[1:0];
        end
      end
    end
  end

  assign headphone_power_down_o      = ctrl_reg[hplrm_pkg::CTL_PDN];
  assign analog_mute_ch_a_o          = ctrl_reg[hplrm_pkg::CTL_MUTE_A];
  assign analog_mute_ch_b_o          = ctrl_reg[hplrm_pkg::CTL_MUTE_B];
  assign playback_highpass_enable_o  = ctrl_reg[hplrm_pkg::CTL_HPF];
  assign supply_latch_select_o       = ctrl_reg[hplrm_pkg::CTL_LATCH];
  assign load_compensation_setting_o = lcomp_reg;

  // ==========================================================
  // Load detection sequencer
  // A sequence only starts with the path quiet and prepared, so the
  // test tone never reaches a live listener
  assign setup_ok = ctrl_reg[hplrm_pkg::CTL_PDN]
                  & ctrl_reg[hplrm_pkg::CTL_MUTE_A]
                  & ctrl_reg[hplrm_pkg::CTL_MUTE_B]
                  & ~ctrl_reg[hplrm_pkg::CTL_HPF]
                  & ctrl_reg[hplrm_pkg::CTL_LATCH]
                  & (mode == hplrm_pkg::MODE_FIX3)
                  & (ramp_reg[hplrm_pkg::RMP_ASR +: 4] == hplrm_pkg::LD_ASR)
                  & (ramp_reg[hplrm_pkg::RMP_DSR +: 4] == hplrm_pkg::LD_DSR);

  assign settled = (settle_reg == '0);

  always_comb begin
    ld_state_next = ld_state_reg;
    case (ld_state_reg)
      LD_IDLE: begin
        if (ins_s2_reg && !ins_d_reg && ctrl_reg[hplrm_pkg::CTL_LD_EN] && setup_ok) begin
          ld_state_next = LD_RES_HI;
        end
      end
      LD_RES_HI: begin
        if (settled) begin
          // Under the 300 ohm point the load is a headphone: no cap test
          ld_state_next = ret_s2_reg ? LD_CAP : LD_RES_LO;
        end
      end
      LD_RES_LO: begin
        if (settled) begin
          ld_state_next = LD_DONE;
        end
      end
      LD_CAP: begin
        if (settled) begin
          ld_state_next = LD_DONE;
        end
      end
      LD_DONE: begin
        ld_state_next = LD_IDLE;
      end
      default: begin
        ld_state_next = LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ld_state_reg <= LD_IDLE;
      settle_reg   <= '0;
    end else begin
      ld_state_reg <= ld_state_next;
      if (ld_state_next != ld_state_reg) begin
        settle_reg <= SW'(SETTLE_CYC - 1);
      end else if (!settled) begin
        settle_reg <= settle_reg - 1'b1;
      end
    end
  end

  // One result pair serves both channels; only channel A is driven
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      res_stat_reg <= hplrm_pkg::RES_15;
      cap_stat_reg <= 1'b0;
      done_reg     <= 1'b0;
    end else begin
      if (ld_state_reg == LD_IDLE && ld_state_next == LD_RES_HI) begin
        done_reg <= 1'b0;
      end
      if (ld_state_reg == LD_RES_HI && settled) begin
        if (ret_s2_reg) begin
          res_stat_reg <= hplrm_pkg::RES_3K;
        end else begin
          cap_stat_reg <= 1'b0;
        end
      end
      if (ld_state_reg == LD_RES_LO && settled) begin
        res_stat_reg <= ret_s2_reg ? hplrm_pkg::RES_30 : hplrm_pkg::RES_15;
      end
      if (ld_state_reg == LD_CAP && settled) begin
        cap_stat_reg <= ret_s2_reg;
      end
      if (ld_state_reg == LD_DONE) begin
        done_reg <= 1'b1;
      end
    end
  end

  // Test tone on channel A and reference bank choice
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tone_o       <= 1'b0;
      tone_cnt_reg <= '0;
      rbank_sel_o  <= hplrm_pkg::BANK_300;
    end else if (ld_state_reg == LD_IDLE || ld_state_reg == LD_DONE) begin
      tone_o       <= 1'b0;
      tone_cnt_reg <= '0;
      rbank_sel_o  <= hplrm_pkg::BANK_300;
    end else begin
      if (tone_cnt_reg == TW'(hplrm_pkg::TONE_HALF_CYC - 1)) begin
        tone_cnt_reg <= '0;
        tone_o       <= ~tone_o;
      end else begin
        tone_cnt_reg <= tone_cnt_reg + 1'b1;
      end
      if (ld_state_next == LD_RES_LO) begin
        rbank_sel_o <= hplrm_pkg::BANK_20;
      end else if (ld_state_next == LD_CAP) begin
        rbank_sel_o <= hplrm_pkg::BANK_CAP;
      end else begin
        rbank_sel_o <= hplrm_pkg::BANK_300;
      end
    end
  end

  assign meas_active_o = (ld_state_reg != LD_IDLE) && (ld_state_reg != LD_DONE);

  // ==========================================================
  // Volume soft ramp
  hplrm_vol_ramp #(.VOL_W(VOL_W)) u_ramp (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .fs_tick_i (fs_tick),
    .ramp_en_i (ctrl_reg[hplrm_pkg::CTL_SS +: 3] == hplrm_pkg::SS_ON),
    .delay_i   (hplrm_pkg::step_periods(ramp_reg[hplrm_pkg::RMP_DSR +: 4])),
    .target_i  (vol_reg),
    .level_o   (vol_applied_o)
  );

  // ==========================================================
  // Rail level control
  assign thr = hplrm_pkg::rail_thresh(res_stat_reg, cap_stat_reg);

  always_comb begin
    if (sig_atten_i <= thr[5:0]) begin
      need_lvl = 2'h0;
    end else if (sig_atten_i <= thr[11:6]) begin
      need_lvl = 2'h1;
    end else if (sig_atten_i <= thr[17:12]) begin
      need_lvl = 2'h2;
    end else begin
      need_lvl = hplrm_pkg::RAIL_LOW;
    end
  end

  always_comb begin
    rail_next = rail_level_o;
    if (mode >= hplrm_pkg::MODE_FIX0 && mode <= hplrm_pkg::MODE_FIX3) begin
      rail_next = 2'(mode - hplrm_pkg::MODE_FIX0);
    end else if (mode == hplrm_pkg::MODE_ADAPT) begin
      if (need_lvl < rail_level_o) begin
        rail_next = rail_level_o - 1'b1;
      end else if (need_lvl > rail_level_o && hold_reg == HW'(HOLD_DOWN_CYC - 1)) begin
        rail_next = rail_level_o + 1'b1;
      end
    end else begin
      // Unassigned codes fall back to the top rail so nothing clips
      rail_next = hplrm_pkg::RAIL_TOP;
    end
  end

  // Hold-off counts only while the signal asks for a lower rail; any
  // demand at or above the present level restarts it
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hold_reg <= '0;
    end else if (mode != hplrm_pkg::MODE_ADAPT || need_lvl <= rail_level_o) begin
      hold_reg <= '0;
    end else if (hold_reg != HW'(HOLD_DOWN_CYC - 1)) begin
      hold_reg <= hold_reg + 1'b1;
    end else if (pump_tick) begin
      hold_reg <= '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rail_level_o <= hplrm_pkg::RAIL_TOP;
    end else if (pump_tick) begin
      rail_level_o <= rail_next;
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  assign ev_set[hplrm_pkg::IRQ_DONE] = (ld_state_reg == LD_DONE);
  assign ev_set[hplrm_pkg::IRQ_UP]   = pump_tick && (rail_next < rail_level_o);
  assign ev_set[hplrm_pkg::IRQ_DOWN] = pump_tick && (rail_next > rail_level_o);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      istat_reg <= '0;
    end else if (reg_wr_i && reg_addr_i == hplrm_pkg::ADDR_ISTAT) begin
      istat_reg <= (istat_reg & ~reg_wdata_i[IRQ_W_L-1:0]) | ev_set;
    end else begin
      istat_reg <= istat_reg | ev_set;
    end
  end

  assign irq_o = |(istat_reg & imask_reg);

  // ==========================================================
  // Read port, data valid the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      if (reg_addr_i == hplrm_pkg::ADDR_CTRL) begin
        reg_rdata_o <= ctrl_reg;
      end else if (reg_addr_i == hplrm_pkg::ADDR_RAMP) begin
        reg_rdata_o <= {24'h0, ramp_reg};
      end else if (reg_addr_i == hplrm_pkg::ADDR_VOL) begin
        reg_rdata_o[VOL_W-1:0]  <= vol_reg;
        reg_rdata_o[VOL_W+15:16] <= vol_applied_o;
      end else if (reg_addr_i == hplrm_pkg::ADDR_LDSTAT) begin
        reg_rdata_o[hplrm_pkg::ST_RES +: 2]  <= res_stat_reg;
        reg_rdata_o[hplrm_pkg::ST_CAP]       <= cap_stat_reg;
        reg_rdata_o[hplrm_pkg::ST_DONE]      <= done_reg;
        reg_rdata_o[hplrm_pkg::ST_BUSY]      <= meas_active_o;
        reg_rdata_o[hplrm_pkg::ST_RAIL +: 2] <= rail_level_o;
      end else if (reg_addr_i == hplrm_pkg::ADDR_ISTAT) begin
        reg_rdata_o[IRQ_W_L-1:0] <= istat_reg;
      end else if (reg_addr_i == hplrm_pkg::ADDR_IMASK) begin
        reg_rdata_o[IRQ_W_L-1:0] <= imask_reg;
      end else if (reg_addr_i == hplrm_pkg::ADDR_LCOMP) begin
        reg_rdata_o[1:0] <= lcomp_reg;
      end
    end
  end
endmodule

// File: rtl/hplrm_vol_ramp.sv
`timescale 1ns/1ns
module hplrm_vol_ramp #(
  parameter int VOL_W = 8
) (
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             fs_tick_i,
  input  wire logic             ramp_en_i,
  input  wire logic [6:0]       delay_i,
  input  wire logic [VOL_W-1:0] target_i,
  output logic      [VOL_W-1:0] level_o
);
  logic [6:0] cnt_reg;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      level_o <= '0;
      cnt_reg <= 7'h01;
    end else if (!ramp_en_i) begin
      level_o <= target_i;
      cnt_reg <= delay_i;
    end else if (level_o == target_i) begin
      cnt_reg <= delay_i;
    end else if (fs_tick_i) begin
      if (cnt_reg <= 7'h01) begin
        cnt_reg <= delay_i;
        if (level_o < target_i) begin
          level_o <= level_o + 1'b1;
        end else begin
          level_o <= level_o - 1'b1;
        end
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// File: shared/hplrm_pkg.sv
// Summary of operation
// - Classify load resistance three ways, capacitance two ways
// - Measure channel A only; loads must match
// - Insertion with detect enabled and setup_ok met starts measurement
// - Drive 24 kHz tone, compare return node
// - Resistance codes 00, 01, 10; never 11
// - Below 300 ohm skips capacitance test
// - Completion sets done flag and done interrupt status
// - Slow start 111 steps volume, 1-72 periods
// - Ramping off applies volume next edge
// - Fixed modes 001-100 hold rail 0-3
// - Adaptive mode moves rail by clip risk
// - Upward change on next pump clock tick
// - Downward change waits 5.5 seconds
// - Adaptive thresholds depend on detected load
package hplrm_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned FS_HZ         = 48_000;
  localparam int unsigned FS_DIV        = CLK_HZ / FS_HZ;
  localparam int unsigned PUMP_HZ       = 500_000;
  localparam int unsigned PUMP_DIV      = CLK_HZ / PUMP_HZ;
  localparam int unsigned TONE_HZ       = 24_000;
  localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned HOLD_DOWN_MS  = 5_500;
  localparam int unsigned HOLD_DOWN_CYC = (CLK_HZ / 1_000) * HOLD_DOWN_MS;
  localparam int unsigned SETTLE_US     = 1_000;
  localparam int unsigned SETTLE_CYC    = (CLK_HZ / 1_000_000) * SETTLE_US;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RAMP   = 8'h04;
  localparam logic [7:0] ADDR_VOL    = 8'h08;
  localparam logic [7:0] ADDR_LDSTAT = 8'h0c;
  localparam logic [7:0] ADDR_ISTAT  = 8'h10;
  localparam logic [7:0] ADDR_IMASK  = 8'h14;
  localparam logic [7:0] ADDR_LCOMP  = 8'h18;
  localparam int CTL_LD_EN  = 0;
  localparam int CTL_PDN    = 1;
  localparam int CTL_MUTE_A = 2;
  localparam int CTL_MUTE_B = 3;
  localparam int CTL_HPF    = 4;
  localparam int CTL_LATCH  = 5;
  localparam int CTL_MODE   = 8;
  localparam int CTL_SS     = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0102;
  localparam int RMP_ASR = 0;
  localparam int RMP_DSR = 4;
  localparam int ST_RES  = 0;
  localparam int ST_CAP  = 2;
  localparam int ST_DONE = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_RAIL = 8;
  localparam int IRQ_W    = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_UP   = 1;
  localparam int IRQ_DOWN = 2;
  // ==========================================================
  // Codes
  localparam logic [2:0] MODE_FIX0  = 3'h1;
  localparam logic [2:0] MODE_FIX3  = 3'h4;
  localparam logic [2:0] MODE_ADAPT = 3'h7;
  localparam logic [2:0] SS_ON      = 3'h7;
  localparam logic [3:0] LD_ASR     = 4'h7;
  localparam logic [3:0] LD_DSR     = 4'h1;
  localparam logic [1:0] RES_15     = 2'h0;
  localparam logic [1:0] RES_30     = 2'h1;
  localparam logic [1:0] RES_3K     = 2'h2;
  localparam logic [1:0] BANK_20    = 2'h0;
  localparam logic [1:0] BANK_300   = 2'h1;
  localparam logic [1:0] BANK_CAP   = 2'h2;
  localparam logic [1:0] RAIL_TOP   = 2'h0;
  localparam logic [1:0] RAIL_LOW   = 2'h3;

  // Sample periods between volume steps per ramp-rate code
  function automatic logic [6:0] step_periods(input logic [3:0] code);
    logic [6:0] p;
    case (code)
      4'h0: p = 7'h01;  4'h1: p = 7'h02;  4'h2: p = 7'h03;  4'h3: p = 7'h04;
      4'h4: p = 7'h06;  4'h5: p = 7'h08;  4'h6: p = 7'h09;  4'h7: p = 7'h0c;
      4'h8: p = 7'h10;  4'h9: p = 7'h12;  4'ha: p = 7'h18;  4'hb: p = 7'h20;
      4'hc: p = 7'h24;  4'hd: p = 7'h30;  4'he: p = 7'h40;  default: p = 7'h48;
    endcase
    return p;
  endfunction

  // Attenuation (dB below full scale) at or under which rails 0,1,2 are needed
  function automatic logic [17:0] rail_thresh(input logic [1:0] res, input logic cap);
    logic [17:0] t;
    if (res == RES_15 && !cap) begin
      t = {6'h14, 6'h0e, 6'h08};
    end else if (res == RES_15) begin
      t = {6'h13, 6'h0e, 6'h09};
    end else if (res == RES_30) begin
      t = {6'h10, 6'h0b, 6'h04};
    end else begin
      t = {6'h0d, 6'h08, 6'h01};
    end
    return t;
  endfunction
endpackage

// File: verification/hplrm_checker.sv
`timescale 1ns/1ns
module hplrm_checker #(
  parameter int unsigned SETTLE_CYC = 20
) (
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        hp_insert_i,
  input wire logic        tone_o,
  input wire logic [1:0]  rbank_sel_o,
  input wire logic        meas_active_o,
  input wire logic        headphone_power_down_o,
  input wire logic        analog_mute_ch_a_o,
  input wire logic [1:0]  load_compensation_setting_o
);
  // Two settle phases per sequence; slack covers sync and the done state
  localparam int MEAS_MAX = 2 * SETTLE_CYC + 8;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ==========================================================
  // Assertions
  a_res_code_legal: assert property (reg_rd_i && reg_addr_i == hplrm_pkg::ADDR_LDSTAT
    |=> reg_rdata_o[1:0] != 2'h3) else $error("reserved resistance code read");
  a_lcomp_gated: assert property (reg_wr_i && reg_addr_i == hplrm_pkg::ADDR_LCOMP
    && !headphone_power_down_o |=> $stable(load_compensation_setting_o))
    else $error("compensation changed while powered");
  a_ctrl_bits_out: assert property (reg_wr_i && reg_addr_i == hplrm_pkg::ADDR_CTRL
    |=> {analog_mute_ch_a_o, headphone_power_down_o} == $past(reg_wdata_i[2:1]))
    else $error("control outputs do not follow write");
  a_start_on_insert: assert property ($rose(meas_active_o) |-> hp_insert_i)
    else $error("measurement started without insertion");
  a_first_bank_high: assert property ($rose(meas_active_o)
    |-> rbank_sel_o == hplrm_pkg::BANK_300) else $error("sequence did not start on 300 ohm bank");
  a_meas_bounded: assert property ($rose(meas_active_o)
    |-> meas_active_o [*8] ##[1:MEAS_MAX] !meas_active_o) else $error("measurement length wrong");
  a_bank_legal: assert property (rbank_sel_o != 2'h3)
    else $error("illegal reference bank");
  a_tone_measuring: assert property (tone_o |-> meas_active_o || $past(meas_active_o))
    else $error("tone outside measurement");
  c_detect: cover property ($rose(meas_active_o));
  c_cap_bank: cover property (meas_active_o && rbank_sel_o == hplrm_pkg::BANK_CAP);
  c_lcomp_write: cover property (reg_wr_i && reg_addr_i == hplrm_pkg::ADDR_LCOMP);
endmodule

bind hplrm_top hplrm_checker #(.SETTLE_CYC(SETTLE_CYC)) i_hplrm_checker (
  .clock_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .hp_insert_i, .tone_o, .rbank_sel_o, .meas_active_o, .headphone_power_down_o,
  .analog_mute_ch_a_o, .load_compensation_setting_o);

// File: verification/tb.sv
`timescale 1ns/1ns
module tb;
  logic        clock_i     = 1'b0;
  logic        srst_i      = 1'b1;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic        hp_insert_i = 1'b0;
  logic        ret_above_i = 1'b0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [5:0]  sig_atten_i = 6'h00;
  logic [2:0]  ret_tab     = 3'h0;
  logic [31:0] reg_rdata_o;
  logic [7:0]  vol_applied_o;
  logic [1:0]  rbank_sel_o, rail_level_o, lcomp;
  logic        tone_o, meas_active_o, irq_o, mute_b, hpf, latch;
  int          err_total   = 0;
  int          n_compared  = 0;
  int          nper [3]    = '{1, 12, 72};
  // Settle long enough that the test tone completes at least one half period
  hplrm_top #(.HOLD_DOWN_CYC(200), .SETTLE_CYC(250), .FS_DIV(4), .PUMP_DIV(3)) i_hplrm_top (
    .clock_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .hp_insert_i, .ret_above_i, .sig_atten_i, .tone_o, .rbank_sel_o, .meas_active_o,
    .rail_level_o, .headphone_power_down_o(), .analog_mute_ch_a_o(), .analog_mute_ch_b_o(mute_b),
    .playback_highpass_enable_o(hpf), .supply_latch_select_o(latch),
    .load_compensation_setting_o(lcomp), .vol_applied_o, .irq_o);
  initial forever #50 clock_i = ~clock_i;
  // Comparator answers per reference bank, as the load under test would
  always @(posedge clock_i) ret_above_i <= ret_tab[rbank_sel_o];
  // ==========================================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp, input string m);
    @(posedge clock_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o & msk, exp, m);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task detect(input logic [2:0] tab, input logic [3:0] exp);
    int tg;
    tg = 0;
    ret_tab = tab;
    @(posedge clock_i) hp_insert_i <= 1'b1;
    for (int i = 0; i < 700 && irq_o !== 1'b1; i++) @(posedge clock_i) tg += int'(tone_o);
    hp_insert_i <= 1'b0;
    rd(hplrm_pkg::ADDR_LDSTAT, 32'hf, {28'h0, exp}, "load result");
    chk(tg > 0, 1, "no tone while measuring");
    wr(hplrm_pkg::ADDR_ISTAT, 32'h1);
    cyc(20);
  endtask
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #2_000_000;
    err_total++;
    give_verdict;
  end
  // ==========================================================
  // Tests
  initial begin
    int t, s;
    logic [7:0] prev, tgt;
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(hplrm_pkg::ADDR_CTRL, 32'hffff_ffff, hplrm_pkg::CTRL_RST, "control reset");
    rd(8'h1c, 32'hffff_ffff, 32'h0, "unmapped read");
    $display("reset test done");
    @(posedge clock_i) sig_atten_i <= 6'h28;
    for (int m = 1; m <= 4; m++) begin
      wr(hplrm_pkg::ADDR_CTRL, 32'h2 | (m << 8));
      cyc(8);
      chk(rail_level_o, m - 1, "fixed rail");
    end
    $display("fixed rail test done");
    wr(hplrm_pkg::ADDR_RAMP, 32'h17);
    wr(hplrm_pkg::ADDR_IMASK, 32'h1);
    wr(hplrm_pkg::ADDR_CTRL, 32'h42e);
    ret_tab = 3'h7;
    @(posedge clock_i) hp_insert_i <= 1'b1;
    cyc(100);
    @(posedge clock_i) hp_insert_i <= 1'b0;
    chk(irq_o, 1'b0, "detect ran while disabled");
    wr(hplrm_pkg::ADDR_CTRL, 32'h42f);
    detect(3'h6, 4'he);
    detect(3'h2, 4'ha);
    detect(3'h4, 4'h8);
    detect(3'h1, 4'h9);
    chk({latch, hpf, mute_b}, 32'h5, "prepared control pins");
    $display("detection test done");
    wr(hplrm_pkg::ADDR_LCOMP, 32'h2);
    rd(hplrm_pkg::ADDR_LCOMP, 32'h3, 32'h2, "compensation write");
    wr(hplrm_pkg::ADDR_CTRL, 32'h0);
    wr(hplrm_pkg::ADDR_LCOMP, 32'h1);
    rd(hplrm_pkg::ADDR_LCOMP, 32'h3, 32'h2, "compensation while powered");
    chk(lcomp, 32'h2, "compensation pins");
    $display("compensation test done");
    wr(hplrm_pkg::ADDR_CTRL, 32'h2);
    wr(hplrm_pkg::ADDR_VOL, 32'h40);
    cyc(1);
    chk(vol_applied_o, 8'h40, "immediate volume");
    wr(hplrm_pkg::ADDR_CTRL, 32'h7002);
    for (int k = 0; k < 3; k++) begin
      wr(hplrm_pkg::ADDR_RAMP, (k == 0) ? 32'h0 : (k == 1) ? 32'h70 : 32'hf0);
      tgt = 8'h43 + 8'(3 * k);
      wr(hplrm_pkg::ADDR_VOL, {24'h0, tgt});
      t = 0;
      s = 0;
      prev = vol_applied_o;
      while (vol_applied_o !== tgt && t < 1000) begin
        cyc(1);
        t++;
        if (vol_applied_o !== prev) s++;
        prev = vol_applied_o;
      end
      chk(s, 3, "ramp step count");
      chk(t >= (2 * nper[k] + 1) * 4 - 4 && t <= 12 * nper[k] + 8, 1, "ramp pace");
    end
    $display("volume test done");
    @(posedge clock_i) sig_atten_i <= 6'h00;
    wr(hplrm_pkg::ADDR_CTRL, 32'h702);
    wr(hplrm_pkg::ADDR_IMASK, 32'h6);
    // Rail events left over from the fixed-mode test must not satisfy the later check
    wr(hplrm_pkg::ADDR_ISTAT, 32'h7);
    cyc(20);
    chk(irq_o, 1'b0, "stale rail events");
    chk(rail_level_o, 2'h0, "adaptive top rail");
    @(posedge clock_i) sig_atten_i <= 6'h05;
    cyc(150);
    chk(rail_level_o, 2'h0, "early step down");
    cyc(60);
    chk(rail_level_o, 2'h1, "step down at 5 dB");
    @(posedge clock_i) sig_atten_i <= 6'h0c;
    cyc(150);
    chk(rail_level_o, 2'h1, "early second step");
    cyc(60);
    chk(rail_level_o, 2'h2, "step down at 12 dB");
    @(posedge clock_i) sig_atten_i <= 6'h04;
    cyc(4);
    chk(rail_level_o <= 2'h1, 1, "fast step up");
    cyc(4);
    chk(rail_level_o, 2'h0, "back to top rail");
    rd(hplrm_pkg::ADDR_ISTAT, 32'h6, 32'h6, "rail events");
    chk(irq_o, 1'b1, "irq raised");
    wr(hplrm_pkg::ADDR_IMASK, 32'h0);
    cyc(1);
    chk(irq_o, 1'b0, "irq masked");
    wr(hplrm_pkg::ADDR_ISTAT, 32'h6);
    rd(hplrm_pkg::ADDR_ISTAT, 32'h7, 32'h0, "events cleared");
    $display("adaptive test done");
    give_verdict;
  end
endmodule
